// *** pkg/shb_class_defines.vh ***
`ifndef SHB_CLASS_DEFINES_VH
`define SHB_CLASS_DEFINES_VH

// frame layout
`define TOP_BAND_LEN      10'h0140
`define ANA_LEN           10'h0120
`define BAND_LEN          6'h20
`define BAND_COUNT        4'h9

// class codes
`define CLASS_NOISE       2'h0
`define CLASS_ONSET       2'h1
`define CLASS_NORMAL      2'h2
`define CLASS_HARMONIC    2'h3

// sharpness thresholds, cross-multiplied
`define SHARP_NUM         7'h3e
`define SHARP_DEN         4'h9
`define NOISE_NUM         7'h1f
`define NOISE_DEN         4'h3
`define PEAK_MIN          16'h0008
`define NOISE_CNT_MIN     4'h4
`define VAR_NUM           3'h5
`define VAR_DEN           5'h18
`define TILT_MAX          16'h0500
`define GAIN_LO_NUM       3'h2
`define GAIN_HI_NUM       3'h5
`define GAIN_HI_DEN       4'h9

// harmonic thresholds
`define ISHARP_WIDE_HARM  4'h4
`define ISHARP_WIDE_ONSET 4'h8
`define ISHARP_WIDE_OTHER 4'h6
`define ISHARP_HARM       4'h2
`define ISHARP_OTHER      4'h8
`define LSHARP_WIDE       16'h000a
`define LSHARP_HARM       16'h0005
`define LSHARP_OTHER      16'h0014
`define CLASS_CNT_MAX     4'hc
`define CLASS_CNT_HOLD    4'h2

// envelope start offsets
`define OFFSET_LOW_RATE   7'h06
`define OFFSET_HIGH_RATE  7'h50

// register map
`define REG_CTRL          12'h000
`define REG_STATUS        12'h004
`define REG_PEAK          12'h008
`define REG_MAG_TOTAL     12'h00c
`define CTRL_WIDE_BIT     0
`define CTRL_RATE_BIT     1

`endif

// *** core/shb_frame_class_coder.v ***
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "shb_class_defines.vh"

module shb_frame_class_coder (
  input  wire        clk,
  input  wire        nrst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        frameStart,
  input  wire        onsetFlag,
  input  wire [15:0] tilt,
  input  wire        coefValid,
  input  wire [15:0] coefData,
  output wire        coefReady,
  output reg  [1:0]  classCode,
  output reg         classValid,
  output wire        frameBusy,
  output reg  [6:0]  envOffset,
  input  wire [3:0]  boundIdx,
  output reg  [8:0]  boundStart,
  output reg  [3:0]  subBandCount
);

  localparam ST_IDLE = 3'h0;
  localparam ST_GAIN = 3'h1;
  localparam ST_ANA  = 3'h2;
  localparam ST_VAR  = 3'h3;
  localparam ST_DEC  = 3'h4;

  reg  [2:0]  state;
  reg  [9:0]  coefIdx;
  reg  [3:0]  bandIdx;
  reg         wideMode;
  reg         highRate;
  reg         frameOnset;
  reg  [15:0] frameTilt;
  reg  [41:0] gainAcc;
  reg  [41:0] prevGain;
  reg  [20:0] bandSum;
  reg  [15:0] bandPeak;
  reg  [15:0] peakMax;
  reg  [23:0] magTotal;
  reg  [33:0] varAcc;
  reg  [3:0]  sharpCnt;
  reg  [3:0]  noiseCnt;
  reg  [3:0]  classCnt;
  reg  [1:0]  prevClass;
  reg  [20:0] bandSums [0:8];
  reg  [3:0]  iSharp;
  reg  [15:0] lSharp;
  reg  [1:0]  next_class;
  reg  [3:0]  next_classCnt;
  reg  [31:0] readMux;

  // the stream is only taken while a frame is being collected
  wire        collecting = (state == ST_GAIN) || (state == ST_ANA);
  wire        take       = coefValid && collecting;
  assign coefReady = collecting;
  assign frameBusy = (state != ST_IDLE);

  // magnitude; the most negative value saturates to keep 15 bits
  wire [15:0] negMag = (coefData == 16'h8000) ? 16'h7fff
                       : (~coefData + 16'h0001);
  wire [15:0] mag    = coefData[15] ? negMag : coefData;
  wire [31:0] magSq = mag * mag;

  // end-of-band values include the current coefficient
  wire [20:0] fullSum  = bandSum + {5'h00, mag};
  wire [15:0] fullPeak = (mag > bandPeak) ? mag : bandPeak;
  wire [20:0] rest     = fullSum - {5'h00, fullPeak};
  wire        bandEnd  = (coefIdx[4:0] == 5'h1f);

  // sharpness 31p/rest > 4.5 <=> 62p > 9 rest
  wire [25:0] sharpLhs = `SHARP_NUM * fullPeak;
  wire [25:0] sharpRhs = `SHARP_DEN * rest;
  wire        isSharp  = (sharpLhs > sharpRhs)
                         && (fullPeak > `PEAK_MIN);
  // sharpness < 3 <=> 31p < 3 rest; empty band has sharpness 0
  wire [25:0] noiseLhs = `NOISE_NUM * fullPeak;
  wire [25:0] noiseRhs = `NOISE_DEN * rest;
  wire        isNoisy  = (fullSum == 21'h00_0000)
                         || (noiseLhs < noiseRhs);

  // variation term for one band: |9 sum_j - total|, scaled by 288
  wire [24:0] nineSum  = `SHARP_DEN * bandSums[bandIdx];
  wire [24:0] totalExt = {1'b0, magTotal};
  wire [24:0] varDev   = (nineSum > totalExt) ? (nineSum - totalExt)
                         : (totalExt - nineSum);

  // gain ratio 0.5 < g/gp < 1.8 <=> 2g > gp and 5g < 9gp
  wire [45:0] gainLo   = `GAIN_LO_NUM * gainAcc;
  wire [45:0] gainHi   = `GAIN_HI_NUM * gainAcc;
  wire [45:0] prevHi   = `GAIN_HI_DEN * prevGain;
  wire        gainOk   = (gainLo > {4'h0, prevGain}) && (gainHi < prevHi);

  // variation < 4.8 mean <=> 5 var < 24 total
  wire [37:0] varLhs   = `VAR_NUM * varAcc;
  wire [37:0] varRhs   = `VAR_DEN * magTotal;

  // thresholds from the previous mode and class
  always @* begin
    if (wideMode) begin
      if (prevClass == `CLASS_HARMONIC)
        iSharp = `ISHARP_WIDE_HARM;
      else if (prevClass == `CLASS_ONSET)
        iSharp = `ISHARP_WIDE_ONSET;
      else
        iSharp = `ISHARP_WIDE_OTHER;
      lSharp = `LSHARP_WIDE;
    end else if (prevClass == `CLASS_HARMONIC) begin
      iSharp = `ISHARP_HARM;
      lSharp = `LSHARP_HARM;
    end else begin
      iSharp = `ISHARP_OTHER;
      lSharp = `LSHARP_OTHER;
    end
  end

  // classification; the counter is left alone on onset frames
  wire directHarm = (sharpCnt > iSharp) && gainOk
                    && (peakMax > lSharp);
  always @* begin
    next_classCnt = classCnt;
    if (frameOnset) begin
      next_class = `CLASS_ONSET;
    end else begin
      if (directHarm) begin
        if (classCnt < `CLASS_CNT_MAX)
          next_classCnt = classCnt + 4'h1;
      end else if (classCnt != 4'h0) begin
        next_classCnt = classCnt - 4'h1;
      end
      if (directHarm || (next_classCnt >= `CLASS_CNT_HOLD))
        next_class = `CLASS_HARMONIC;
      else if ((noiseCnt > `NOISE_CNT_MIN) && (varLhs < varRhs)
               && (frameTilt < `TILT_MAX))
        next_class = `CLASS_NOISE;
      else
        next_class = `CLASS_NORMAL;
    end
  end

  // frame sequencer: 320 top band coefs, then 288 analysis coefs
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state      <= ST_IDLE;
      coefIdx    <= 10'h000;
      bandIdx    <= 4'h0;
      frameOnset <= 1'b0;
      frameTilt  <= 16'h0000;
      gainAcc    <= 42'h000_0000_0000;
      prevGain   <= 42'h000_0000_0000;
      bandSum    <= 21'h00_0000;
      bandPeak   <= 16'h0000;
      peakMax    <= 16'h0000;
      magTotal   <= 24'h00_0000;
      varAcc     <= 34'h0_0000_0000;
      sharpCnt   <= 4'h0;
      noiseCnt   <= 4'h0;
      classCnt   <= 4'h0;
      prevClass  <= `CLASS_NOISE;
      classCode  <= `CLASS_NOISE;
      classValid <= 1'b0;
    end else begin
      classValid <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (frameStart) begin
            frameOnset <= onsetFlag;
            frameTilt  <= tilt;
            coefIdx    <= 10'h000;
            bandIdx    <= 4'h0;
            gainAcc    <= 42'h000_0000_0000;
            bandSum    <= 21'h00_0000;
            bandPeak   <= 16'h0000;
            peakMax    <= 16'h0000;
            magTotal   <= 24'h00_0000;
            varAcc     <= 34'h0_0000_0000;
            sharpCnt   <= 4'h0;
            noiseCnt   <= 4'h0;
            state      <= ST_GAIN;
          end
        end
        ST_GAIN: begin
          if (take) begin
            gainAcc <= gainAcc + {10'h000, magSq};
            if (coefIdx == `TOP_BAND_LEN - 10'h001) begin
              coefIdx <= 10'h000;
              state   <= ST_ANA;
            end else begin
              coefIdx <= coefIdx + 10'h001;
            end
          end
        end
        ST_ANA: begin
          if (take) begin
            magTotal <= magTotal + {8'h00, mag};
            if (bandEnd) begin
              // band closes: store sum, update peaks and counters
              bandSums[bandIdx] <= fullSum;
              bandSum  <= 21'h00_0000;
              bandPeak <= 16'h0000;
              if (fullPeak > peakMax)
                peakMax <= fullPeak;
              if (isSharp)
                sharpCnt <= sharpCnt + 4'h1;
              if (isNoisy)
                noiseCnt <= noiseCnt + 4'h1;
              bandIdx <= bandIdx + 4'h1;
            end else begin
              bandSum  <= fullSum;
              bandPeak <= fullPeak;
            end
            if (coefIdx == `ANA_LEN - 10'h001) begin
              bandIdx <= 4'h0;
              state   <= ST_VAR;
            end else begin
              coefIdx <= coefIdx + 10'h001;
            end
          end
        end
        ST_VAR: begin
          // one band per cycle; the total is only known here
          varAcc <= varAcc + {9'h000, varDev};
          if (bandIdx == `BAND_COUNT - 4'h1)
            state <= ST_DEC;
          else
            bandIdx <= bandIdx + 4'h1;
        end
        ST_DEC: begin
          classCode  <= next_class;
          prevClass  <= next_class;
          classCnt   <= next_classCnt;
          prevGain   <= gainAcc;
          classValid <= 1'b1;
          state      <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // sub-band boundary lookup for the class last emitted
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      boundStart   <= 9'h000;
      subBandCount <= 4'h0;
      envOffset    <= `OFFSET_LOW_RATE;
    end else begin
      envOffset <= highRate ? `OFFSET_HIGH_RATE : `OFFSET_LOW_RATE;
      if (classCode == `CLASS_ONSET) begin
        subBandCount <= 4'h4;
        case (boundIdx)
          4'h0:    boundStart <= 9'h000;
          4'h1:    boundStart <= 9'h04c;
          4'h2:    boundStart <= 9'h098;
          4'h3:    boundStart <= 9'h0ec;
          default: boundStart <= 9'h140;
        endcase
      end else begin
        subBandCount <= 4'he;
        case (boundIdx)
          4'h0:    boundStart <= 9'h000;
          4'h1:    boundStart <= 9'h010;
          4'h2:    boundStart <= 9'h028;
          4'h3:    boundStart <= 9'h038;
          4'h4:    boundStart <= 9'h050;
          4'h5:    boundStart <= 9'h060;
          4'h6:    boundStart <= 9'h078;
          4'h7:    boundStart <= 9'h088;
          4'h8:    boundStart <= 9'h0a0;
          4'h9:    boundStart <= 9'h0b8;
          4'ha:    boundStart <= 9'h0d0;
          4'hb:    boundStart <= 9'h0e8;
          4'hc:    boundStart <= 9'h100;
          4'hd:    boundStart <= 9'h120;
          default: boundStart <= 9'h140;
        endcase
      end
    end
  end

  // apb slave: zero wait states, error on unmapped addresses
  wire mapped = (paddr == `REG_CTRL) || (paddr == `REG_STATUS)
                || (paddr == `REG_PEAK) || (paddr == `REG_MAG_TOTAL);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // control register: previous mode and rate select
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wideMode <= 1'b0;
      highRate <= 1'b0;
    end else if (psel && penable && pwrite && (paddr == `REG_CTRL)) begin
      wideMode <= pwdata[`CTRL_WIDE_BIT];
      highRate <= pwdata[`CTRL_RATE_BIT];
    end
  end

  // read mux; unmapped reads return zero
  always @* begin
    case (paddr)
      `REG_CTRL:      readMux = {30'h0000_0000, highRate, wideMode};
      `REG_STATUS:    readMux = {15'h0000, frameBusy, noiseCnt, sharpCnt,
                                 classCnt, 2'h0, classCode};
      `REG_PEAK:      readMux = {16'h0000, peakMax};
      `REG_MAG_TOTAL: readMux = {8'h00, magTotal};
      default:        readMux = 32'h0000_0000;
    endcase
  end

  // read data is captured in the setup phase, so it holds steady
  // through the access phase even if status moves on that edge
  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      prdata <= 32'h0000_0000;
    else if (psel && !penable)
      prdata <= readMux;
  end

endmodule

// *** tb/coef_source.sv ***
`timescale 1ns/1ps
module coef_source (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        go,
  input  wire logic        onset,
  input  wire logic        fast,
  input  wire logic [15:0] tiltIn,
  input  wire logic [15:0] amp,
  input  wire logic        coefReady,
  output logic             frameStart,
  output logic             onsetFlag,
  output logic      [15:0] tilt,
  output logic             coefValid,
  output logic      [15:0] coefData
);
  logic       busy;
  logic [9:0] k;

  // one peak per 32 coefficients, magnitude 1 elsewhere
  function automatic logic [15:0] pat(input logic [9:0] i);
    return i[4:0] == 5'h00 ? amp : 16'h0001;
  endfunction

  // 320 gain coefs then 288 analysis coefs; slow mode idles a cycle between coefs
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      frameStart <= 1'b0;
      onsetFlag <= 1'b0;
      tilt <= 16'h0000;
      coefValid <= 1'b0;
      coefData <= 16'h0000;
      busy <= 1'b0;
      k <= 10'h000;
    end else begin
      frameStart <= 1'b0;
      tilt <= ~tilt;             // only meaningful with frameStart
      onsetFlag <= ~onsetFlag;
      if (go && !busy) begin
        frameStart <= 1'b1;
        onsetFlag <= onset;
        tilt <= tiltIn;
        busy <= 1'b1;
        k <= 10'h000;
      end else if (coefValid && coefReady) begin
        k <= k + 10'h001;
        busy <= k != 10'h25f;
        coefValid <= fast && k != 10'h25f;
        coefData <= fast ? pat(k + 10'h001) : ~coefData;
      end else if (busy && !coefValid && !frameStart) begin
        coefValid <= 1'b1;
        coefData <= pat(k);
      end
    end
  end
endmodule

// *** tb/shb_frame_class_coder_props.sv ***
`timescale 1ns/1ps
`include "shb_class_defines.vh"
module shb_class_checker (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        frameStart,
  input wire logic        onsetFlag,
  input wire logic        frameBusy,
  input wire logic [1:0]  classCode,
  input wire logic        classValid,
  input wire logic [6:0]  envOffset,
  input wire logic [3:0]  boundIdx,
  input wire logic [8:0]  boundStart,
  input wire logic [3:0]  subBandCount
);
  logic lastOnset;
  wire  acc = psel && penable;

  // remember the onset decision of the frame in flight
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      lastOnset <= 1'b0;
    else if (frameStart && !frameBusy)
      lastOnset <= onsetFlag;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_ready_high: assert property (pready)
    else $error("pready low");
  chk_unmapped_err: assert property (acc && paddr > 12'h00c
    |-> pslverr && prdata == 32'h0000_0000) else $error("no slave error");
  chk_valid_pulse: assert property (classValid |=> !classValid)
    else $error("class pulse too long");
  chk_code_hold: assert property (!classValid |-> $stable(classCode))
    else $error("class code moved");
  chk_onset_class: assert property (classValid && lastOnset
    |-> classCode == `CLASS_ONSET) else $error("onset not transient");
  chk_busy_start: assert property (frameStart && !frameBusy |=> frameBusy)
    else $error("frame not started");
  chk_band_count: assert property (frameBusy
    |-> subBandCount == (classCode == `CLASS_ONSET ? 4'h4 : 4'he))
    else $error("sub-band count wrong");
  chk_env_rate: assert property (acc && pwrite && paddr == 12'h000
    |-> ##2 envOffset == ($past(pwdata[1], 2) ? 7'h50 : 7'h06))
    else $error("offset wrong");
  chk_bound_end: assert property ($past(nrst)
    && $past(boundIdx) > 4'hd |-> boundStart == 9'h140)
    else $error("end boundary wrong");
  chk_counter_range: assert property (acc && paddr == 12'h004
    |-> prdata[7:4] <= 4'hc) else $error("class counter too big");
endmodule

bind shb_frame_class_coder shb_class_checker i_chk (.clk, .nrst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .frameStart, .onsetFlag, .frameBusy, .classCode, .classValid,
  .envOffset, .boundIdx, .boundStart, .subBandCount);

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  logic        clk, nrst, psel, penable, pwrite, pready, pslverr, err;
  logic        frameStart, onsetFlag, coefValid, coefReady, classValid;
  logic        frameBusy, go, onset, fast;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] tilt, coefData, tiltIn, amp;
  logic [1:0]  classCode;
  logic [6:0]  envOffset;
  logic [3:0]  boundIdx, subBandCount;
  logic [8:0]  boundStart;
  int          errCount, cmpCount;

  shb_frame_class_coder i_dut (.clk, .nrst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .frameStart, .onsetFlag,
    .tilt, .coefValid, .coefData, .coefReady, .classCode, .classValid,
    .frameBusy, .envOffset, .boundIdx, .boundStart, .subBandCount);
  coef_source i_src (.clk, .nrst, .go, .onset, .fast, .tiltIn, .amp,
    .coefReady, .frameStart, .onsetFlag, .tilt, .coefValid, .coefData);

  // free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp) begin
      errCount++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // setup edge, access edge, then hold until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // outputs are sampled on the falling edge, where they have settled
  task automatic frame(input logic o, input logic [15:0] t,
                       input logic [15:0] a, input logic f,
                       input logic [1:0] exp);
    @(posedge clk);
    go <= 1'b1;
    onset <= o;
    tiltIn <= t;
    amp <= a;
    fast <= f;
    @(posedge clk);
    go <= 1'b0;
    do @(negedge clk); while (classValid !== 1'b1);
    cmp(classCode, exp);
    $display("frame done, class %h", classCode);
  endtask

  function automatic logic [31:0] bexp(input logic o, input int i);
    int b;
    b = 0;
    if (o)
      return i > 3 ? 320 : (i == 3 ? 236 : i * 76);
    for (int j = 0; j < i && j < 14; j++)
      b += j < 8 ? (j % 2 ? 24 : 16) : (j < 12 ? 24 : 32);
    return b;
  endfunction

  // walk every index, including those past the last boundary
  task automatic bounds(input logic o);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      boundIdx <= i[3:0];
      @(posedge clk);
      @(negedge clk);
      cmp(boundStart, bexp(o, i));
    end
    cmp(subBandCount, o ? 4 : 14);
    $display("boundary walk done");
  endtask

  task automatic wrapUp;
    $display("comparisons %0d mismatches %0d", cmpCount, errCount);
    if (errCount == 0 && cmpCount > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // a hang ends the run as a mismatch
  initial begin
    #400000;
    errCount++;
    wrapUp;
  end

  initial begin
    {psel, penable, pwrite, go, onset, fast} = '0;
    paddr = '0;
    pwdata = '0;
    tiltIn = '0;
    amp = '0;
    boundIdx = '0;
    errCount = 0;
    cmpCount = 0;
    nrst = 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    cmp(envOffset, 32'h0000_0006);
    apb(1'b1, 12'h000, 32'h0000_0002);
    apb(1'b0, 12'h000, 32'h0000_0000);
    cmp(rd, 32'h0000_0002);
    @(negedge clk);
    cmp(envOffset, 32'h0000_0050);
    apb(1'b1, 12'h000, 32'h0000_0000);
    apb(1'b0, 12'h010, 32'h0000_0000);
    cmp({31'h0, err}, 32'h0000_0001);
    cmp(rd, 32'h0000_0000);
    frame(1'b1, 16'h0000, 16'h0064, 1'b1, 2'h1);
    bounds(1'b1);
    frame(1'b0, 16'h0100, 16'h0001, 1'b0, 2'h0);
    bounds(1'b0);
    frame(1'b0, 16'h0600, 16'h0001, 1'b1, 2'h2);
    frame(1'b0, 16'h0100, 16'h0064, 1'b1, 2'h2);
    repeat (3) frame(1'b0, 16'h0100, 16'h0064, 1'b1, 2'h3);
    apb(1'b0, 12'h004, 32'h0000_0000);
    cmp(rd, 32'h0000_0933);
    apb(1'b0, 12'h008, 32'h0000_0000);
    cmp(rd, 32'h0000_0064);
    apb(1'b0, 12'h00c, 32'h0000_0000);
    cmp(rd, 32'h0000_049b);
    frame(1'b0, 16'h0100, 16'h0001, 1'b0, 2'h3);
    frame(1'b0, 16'h0100, 16'h0001, 1'b1, 2'h0);
    apb(1'b0, 12'h004, 32'h0000_0000);
    cmp(rd, 32'h0000_9010);
    apb(1'b1, 12'h000, 32'h0000_0001);
    frame(1'b0, 16'h0100, 16'h000c, 1'b1, 2'h2);
    frame(1'b0, 16'h0100, 16'h000c, 1'b1, 2'h3);
    // a mid-run reset must clear counter, class and previous gain
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, 12'h004, 32'h0000_0000);
    cmp(rd, 32'h0000_0000);
    frame(1'b0, 16'h0100, 16'h0064, 1'b1, 2'h2);
    wrapUp;
  end
endmodule
